// *** include/ext_event_pkg.sv ***
// Constants, register map and bus state type for the external event controller.
// Assumes a single 10 MHz clock and a classic Wishbone register port.
`default_nettype none
package ext_event_pkg;

    // ******
    // sizes
    // ******
    localparam int N_LINES_DEF = 19;
    localparam int N_EXT_DEF   = 16;
    localparam int N_PINS_DEF  = 51;
    localparam int SEL_W_DEF   = 6;
    localparam int ADR_W       = 8;
    localparam int DAT_W       = 32;

    // ******
    // register map (byte addresses)
    // ******
    localparam logic [7:0] OFS_INT_MASK = 8'h00;
    localparam logic [7:0] OFS_EVT_MASK = 8'h04;
    localparam logic [7:0] OFS_RISE_SEL = 8'h08;
    localparam logic [7:0] OFS_FALL_SEL = 8'h0c;
    localparam logic [7:0] OFS_PENDING  = 8'h10;
    localparam logic [7:0] OFS_SW_TRIG  = 8'h14;
    // pin selectors: page 1 (0x40..0x7c), one word per external line
    localparam logic [1:0] SEL_PAGE     = 2'h1;
    localparam int         PAGE_LSB     = 6;
    localparam int         IDX_LSB      = 2;
    localparam int         IDX_W        = 4;

    // ******
    // reset values
    // ******
    localparam logic [31:0] MASK_RST = 32'h0000_0000;
    localparam logic [31:0] EDGE_RST = 32'h0000_0000;
    localparam logic [31:0] SEL_RST  = 32'h0000_0000;

    // ******
    // bus slave states
    // ******
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } bus_state_t;

endpackage : ext_event_pkg
`default_nettype wire

// *** src/edge_capture.sv ***
// One edge-detector line: turns the selected transitions of its source into a one-cycle hit.
// Assumes rise_en/fall_en come from clk logic; sig is a pin when ASYNC=1, clk logic otherwise.
`timescale 1ns/100ps
`default_nettype none
module edge_capture #(
    parameter bit ASYNC = 1'b1
) (
    input  wire logic clk,     // system clock
    input  wire logic rst_n,   // synchronised reset, active low
    input  wire logic sig,     // line source
    input  wire logic rise_en, // rising transition triggers
    input  wire logic fall_en, // falling transition triggers
    output logic      hit      // one-cycle pulse per edge
);

    logic hit_r;

    generate
        if (ASYNC) begin : g_async
            // ******
            // edge-clocked toggles
            // ******
            logic       rise_tog_r;
            logic       fall_tog_r;
            logic [2:0] rise_sy_r;
            logic [2:0] fall_sy_r;
            logic       rise_seen_r;
            logic       fall_seen_r;
            logic       rise_ok;
            logic       fall_ok;

            // the pin edge itself clocks the toggle, so no pulse is too short
            always_ff @(posedge sig or negedge rst_n) begin
                if (!rst_n) begin
                    rise_tog_r <= 1'b0;
                end else if (rise_en) begin
                    rise_tog_r <= ~rise_tog_r;
                end
            end

            always_ff @(negedge sig or negedge rst_n) begin
                if (!rst_n) begin
                    fall_tog_r <= 1'b0;
                end else if (fall_en) begin
                    fall_tog_r <= ~fall_tog_r;
                end
            end

            // ******
            // three-flop crossing into clk
            // ******
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    rise_sy_r <= 3'h0;
                    fall_sy_r <= 3'h0;
                end else begin
                    rise_sy_r <= {rise_sy_r[1:0], rise_tog_r};
                    fall_sy_r <= {fall_sy_r[1:0], fall_tog_r};
                end
            end

            // a change counts once stages two and three agree
            assign rise_ok = (rise_sy_r[1] == rise_sy_r[2]);
            assign fall_ok = (fall_sy_r[1] == fall_sy_r[2]);

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    rise_seen_r <= 1'b0;
                    fall_seen_r <= 1'b0;
                    hit_r       <= 1'b0;
                end else begin
                    if (rise_ok) begin
                        rise_seen_r <= rise_sy_r[2];
                    end
                    if (fall_ok) begin
                        fall_seen_r <= fall_sy_r[2];
                    end
                    hit_r <= (rise_ok && (rise_sy_r[2] != rise_seen_r))
                           | (fall_ok && (fall_sy_r[2] != fall_seen_r));
                end
            end
        end else begin : g_sync
            // internal sources share clk: plain registered compare
            logic prev_r;

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    prev_r <= 1'b0;
                    hit_r  <= 1'b0;
                end else begin
                    prev_r <= sig;
                    hit_r  <= (rise_en & sig & ~prev_r)
                            | (fall_en & ~sig & prev_r);
                end
            end
        end
    endgenerate

    assign hit = hit_r;

endmodule : edge_capture
`default_nettype wire

// *** src/pin_route.sv ***
// Pin multiplexer: routes one selected pin to each external line.
// Assumes selectors come from clk registers; out-of-range codes give a quiet low.
`timescale 1ns/100ps
`default_nettype none
module pin_route #(
    parameter int N_EXT  = 16,
    parameter int N_PINS = 51,
    parameter int SEL_W  = 6
) (
    input  wire logic [N_PINS-1:0]      pins,   // pin levels
    input  wire logic [N_EXT*SEL_W-1:0] sel,    // packed selectors
    output logic      [N_EXT-1:0]       routed  // one source per line
);

    // ******
    // one mux per external line
    // ******
    genvar i;
    generate
        for (i = 0; i < N_EXT; i++) begin : g_mux
            logic [SEL_W-1:0] s;
            assign s         = sel[i*SEL_W +: SEL_W];
            assign routed[i] = (32'(s) < N_PINS) ? pins[s] : 1'b0;
        end
    endgenerate

endmodule : pin_route
`default_nettype wire

// *** src/ext_event_ctrl.sv ***
// Top of the external event controller: Wishbone registers, pin routing,
// per-line edge detection, pending status and request outputs.
// Assumes a 10 MHz clk, asynchronous active-low rst_n and internal sources on clk.
`timescale 1ns/100ps
`default_nettype none
module ext_event_ctrl
    import ext_event_pkg::*;
#(
    parameter int N_LINES = N_LINES_DEF,
    parameter int N_EXT   = N_EXT_DEF,
    parameter int N_PINS  = N_PINS_DEF,
    parameter int SEL_W   = SEL_W_DEF
) (
    input  wire logic                 clk,       // 10 MHz system clock
    input  wire logic                 rst_n,     // async reset, active low
    input  wire logic                 wb_cyc_i,  // bus cycle
    input  wire logic                 wb_stb_i,  // bus strobe
    input  wire logic                 wb_we_i,   // write when high
    input  wire logic [ADR_W-1:0]     wb_adr_i,  // byte address
    input  wire logic [3:0]           wb_sel_i,  // byte enables
    input  wire logic [DAT_W-1:0]     wb_dat_i,  // write data
    output logic      [DAT_W-1:0]     wb_dat_o,  // read data
    output logic                      wb_ack_o,  // one-cycle ack
    input  wire logic [N_PINS-1:0]    gpio_pins, // external pins
    input  wire logic [N_LINES-N_EXT-1:0] int_src, // internal sources
    output logic      [N_LINES-1:0]   irq_req,   // interrupt requests
    output logic      [N_LINES-1:0]   evt_req    // event pulses
);

    // ******
    // elaboration checks
    // ******
    generate
        if (N_LINES > DAT_W || N_EXT > N_LINES || N_EXT < 1 ||
            N_LINES - N_EXT < 1 || N_EXT > 2**IDX_W ||
            N_PINS > 2**SEL_W || SEL_W > DAT_W) begin : g_bad
            $error("ext_event_ctrl: unsupported sizes");
        end
    endgenerate

    // ******
    // reset release
    // ******
    logic [1:0] rst_q_r;
    logic       rst_sync_n;

    // two flops so release is clean against clk
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_q_r <= 2'b00;
        end else begin
            rst_q_r <= {rst_q_r[0], 1'b1};
        end
    end

    assign rst_sync_n = rst_q_r[1];

    // ******
    // bus slave
    // ******
    bus_state_t       bus_state_r;
    logic             take;
    logic             wr_take;
    logic             rd_take;
    logic [DAT_W-1:0] wmask;
    logic             ack_r;
    logic [DAT_W-1:0] rdata_r;
    logic [DAT_W-1:0] rdata_nxt;

    // a request is taken only in idle, so ack lasts exactly one cycle
    assign take    = (bus_state_r == BUS_IDLE) && wb_cyc_i && wb_stb_i;
    assign wr_take = take && wb_we_i;
    assign rd_take = take && !wb_we_i;
    assign wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                      {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // byte-lane merge of a write into an old register value
    function automatic logic [DAT_W-1:0] merge(
        input logic [DAT_W-1:0] old_v,
        input logic [DAT_W-1:0] new_v,
        input logic [DAT_W-1:0] m
    );
        merge = (old_v & ~m) | (new_v & m);
    endfunction : merge

    // idle -> ack -> idle, one cycle each
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            bus_state_r <= BUS_IDLE;
            ack_r       <= 1'b0;
        end else begin
            unique case (bus_state_r)
                BUS_IDLE: begin
                    ack_r <= take;
                    if (take) begin
                        bus_state_r <= BUS_ACK;
                    end
                end
                BUS_ACK: begin
                    ack_r       <= 1'b0;
                    bus_state_r <= BUS_IDLE;
                end
                default: begin
                    ack_r       <= 1'b0;
                    bus_state_r <= BUS_IDLE;
                end
            endcase
        end
    end

    // ******
    // address decode
    // ******
    logic                  a_int_mask;
    logic                  a_evt_mask;
    logic                  a_rise;
    logic                  a_fall;
    logic                  a_pend;
    logic                  a_swtrig;
    logic                  a_sel;
    logic [IDX_W-1:0]      sel_idx;

    assign a_int_mask = (wb_adr_i == OFS_INT_MASK);
    assign a_evt_mask = (wb_adr_i == OFS_EVT_MASK);
    assign a_rise     = (wb_adr_i == OFS_RISE_SEL);
    assign a_fall     = (wb_adr_i == OFS_FALL_SEL);
    assign a_pend     = (wb_adr_i == OFS_PENDING);
    assign a_swtrig   = (wb_adr_i == OFS_SW_TRIG);
    assign sel_idx    = wb_adr_i[IDX_LSB +: IDX_W];
    // low address bits must be zero: only aligned words are mapped
    assign a_sel      = (wb_adr_i[ADR_W-1:PAGE_LSB] == SEL_PAGE) &&
                        (wb_adr_i[IDX_LSB-1:0] == '0) &&
                        (32'(sel_idx) < N_EXT);

    // ******
    // configuration registers
    // ******
    logic [N_LINES-1:0] int_mask_r;
    logic [N_LINES-1:0] evt_mask_r;
    logic [N_LINES-1:0] rise_en_r;
    logic [N_LINES-1:0] fall_en_r;

    // mask: 1 lets a line through, 0 suppresses only that line
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            int_mask_r <= N_LINES'(MASK_RST);
            evt_mask_r <= N_LINES'(MASK_RST);
        end else if (wr_take) begin
            if (a_int_mask) begin
                int_mask_r <= N_LINES'(merge(32'(int_mask_r), wb_dat_i, wmask));
            end
            if (a_evt_mask) begin
                evt_mask_r <= N_LINES'(merge(32'(evt_mask_r), wb_dat_i, wmask));
            end
        end
    end

    // both bits set gives either transition
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rise_en_r <= N_LINES'(EDGE_RST);
            fall_en_r <= N_LINES'(EDGE_RST);
        end else if (wr_take) begin
            if (a_rise) begin
                rise_en_r <= N_LINES'(merge(32'(rise_en_r), wb_dat_i, wmask));
            end
            if (a_fall) begin
                fall_en_r <= N_LINES'(merge(32'(fall_en_r), wb_dat_i, wmask));
            end
        end
    end

    // ******
    // pin selectors
    // ******
    logic [SEL_W-1:0]       pin_sel_r [N_EXT];
    logic [N_EXT*SEL_W-1:0] pin_sel_flat;
    logic [N_EXT-1:0]       routed;

    genvar k;
    generate
        for (k = 0; k < N_EXT; k++) begin : g_sel
            // retargeting a live line may fake an edge: mask it first
            always_ff @(posedge clk or negedge rst_sync_n) begin
                if (!rst_sync_n) begin
                    pin_sel_r[k] <= SEL_W'(SEL_RST);
                end else if (wr_take && a_sel && (32'(sel_idx) == k)) begin
                    pin_sel_r[k] <= SEL_W'(merge(32'(pin_sel_r[k]), wb_dat_i, wmask));
                end
            end
            assign pin_sel_flat[k*SEL_W +: SEL_W] = pin_sel_r[k];
        end
    endgenerate

    pin_route #(
        .N_EXT  (N_EXT),
        .N_PINS (N_PINS),
        .SEL_W  (SEL_W)
    ) u_route (
        .pins   (gpio_pins),
        .sel    (pin_sel_flat),
        .routed (routed)
    );

    // ******
    // edge detector lines
    // ******
    logic [N_LINES-1:0] hit;

    genvar j;
    generate
        for (j = 0; j < N_LINES; j++) begin : g_line
            if (j < N_EXT) begin : g_ext
                edge_capture #(
                    .ASYNC   (1'b1)
                ) u_cap (
                    .clk     (clk),
                    .rst_n   (rst_sync_n),
                    .sig     (routed[j]),
                    .rise_en (rise_en_r[j]),
                    .fall_en (fall_en_r[j]),
                    .hit     (hit[j])
                );
            end else begin : g_int
                edge_capture #(
                    .ASYNC   (1'b0)
                ) u_cap (
                    .clk     (clk),
                    .rst_n   (rst_sync_n),
                    .sig     (int_src[j-N_EXT]),
                    .rise_en (rise_en_r[j]),
                    .fall_en (fall_en_r[j]),
                    .hit     (hit[j])
                );
            end
        end
    endgenerate

    // ******
    // software trigger and pending
    // ******
    logic [N_LINES-1:0] sw_set;
    logic [N_LINES-1:0] pend_clr;
    logic [N_LINES-1:0] pend_set;
    logic [N_LINES-1:0] pend_r;

    // write-one pulses, valid only in the take cycle
    assign sw_set   = (wr_take && a_swtrig) ? N_LINES'(wb_dat_i & wmask) : '0;
    assign pend_clr = (wr_take && a_pend) ? N_LINES'(wb_dat_i & wmask) : '0;
    // masked lines never go pending
    assign pend_set = (hit | sw_set) & int_mask_r;

    // set beats clear so a coincident edge is not lost
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pend_r <= '0;
        end else begin
            pend_r <= (pend_r & ~pend_clr) | pend_set;
        end
    end

    // ******
    // request outputs
    // ******
    logic [N_LINES-1:0] irq_r;
    logic [N_LINES-1:0] evt_r;

    // level while pending and unmasked; one cycle behind pend_r
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            irq_r <= '0;
        end else begin
            irq_r <= pend_r & int_mask_r;
        end
    end

    // events carry no state: one pulse per edge
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            evt_r <= '0;
        end else begin
            evt_r <= (hit | sw_set) & evt_mask_r;
        end
    end

    // ******
    // read back
    // ******
    always_comb begin
        rdata_nxt = '0;
        if (a_int_mask) begin
            rdata_nxt = 32'(int_mask_r);
        end else if (a_evt_mask) begin
            rdata_nxt = 32'(evt_mask_r);
        end else if (a_rise) begin
            rdata_nxt = 32'(rise_en_r);
        end else if (a_fall) begin
            rdata_nxt = 32'(fall_en_r);
        end else if (a_pend) begin
            rdata_nxt = 32'(pend_r);
        end else if (a_sel) begin
            rdata_nxt = 32'(pin_sel_r[sel_idx]);
        end
    end

    // unmapped and sw-trigger reads return zero
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rdata_r <= '0;
        end else if (rd_take) begin
            rdata_r <= rdata_nxt;
        end
    end

    assign wb_dat_o = rdata_r;
    assign wb_ack_o = ack_r;
    assign irq_req  = irq_r;
    assign evt_req  = evt_r;

endmodule : ext_event_ctrl
`default_nettype wire

// *** verification/ext_event_ctrl_sva.sv ***
// Port-level checks for the external event controller.
// Assumes a classic Wishbone master and bind onto ext_event_ctrl.
`timescale 1ns/100ps
`default_nettype none
module ext_event_ctrl_sva
    import ext_event_pkg::*;
#(
    parameter int N_LINES = N_LINES_DEF,
    parameter int N_EXT   = N_EXT_DEF,
    parameter int N_PINS  = N_PINS_DEF,
    parameter int SEL_W   = SEL_W_DEF
) (
    input wire logic                     clk,       // clock
    input wire logic                     rst_n,     // reset, active low
    input wire logic                     wb_cyc_i,  // cycle
    input wire logic                     wb_stb_i,  // strobe
    input wire logic                     wb_we_i,   // write
    input wire logic [ADR_W-1:0]         wb_adr_i,  // address
    input wire logic [3:0]               wb_sel_i,  // lanes
    input wire logic [DAT_W-1:0]         wb_dat_i,  // write data
    input wire logic [DAT_W-1:0]         wb_dat_o,  // read data
    input wire logic                     wb_ack_o,  // ack
    input wire logic [N_PINS-1:0]        gpio_pins, // pins
    input wire logic [N_LINES-N_EXT-1:0] int_src,   // internal sources
    input wire logic [N_LINES-1:0]       irq_req,   // requests
    input wire logic [N_LINES-1:0]       evt_req    // events
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic rd_ack;
    logic wr_ack;
    // read and write answers as seen by the master
    assign rd_ack = wb_ack_o && !wb_we_i;
    assign wr_ack = wb_ack_o && wb_we_i;
    // ******
    // bus and register view
    // ******
    property p_ack_once; $rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o ##1 !wb_ack_o; endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack not one cycle after request");
    property p_rd_hold; !rd_ack |-> $stable(wb_dat_o); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");
    property p_line_rd; rd_ack && wb_adr_i <= OFS_SW_TRIG |-> wb_dat_o[DAT_W-1:N_LINES] == '0; endproperty
    a_line_rd: assert property (p_line_rd) else $error("bits above the lines read nonzero");
    property p_zero_rd; rd_ack && wb_adr_i[7:6] == 2'h0 && wb_adr_i > OFS_PENDING |-> wb_dat_o == '0;
    endproperty
    a_zero_rd: assert property (p_zero_rd) else $error("trigger or empty place read nonzero");
    property p_sel_rd; rd_ack && wb_adr_i[7:6] == SEL_PAGE |-> wb_dat_o[DAT_W-1:SEL_W] == '0; endproperty
    a_sel_rd: assert property (p_sel_rd) else $error("selector upper bits nonzero");
    // ******
    // request outputs
    // ******
    property p_mask_off;
        wr_ack && wb_adr_i == OFS_INT_MASK && wb_sel_i == 4'hf && wb_dat_i == '0 |=> irq_req == '0;
    endproperty
    a_mask_off: assert property (p_mask_off) else $error("request survives full mask");
    // quiet internal source, so a new set cannot win over the clear
    property p_clr;
        wr_ack && wb_adr_i == OFS_PENDING && wb_dat_i[16] && wb_sel_i[2] && $past(int_src, 4) == int_src
            |=> !irq_req[16];
    endproperty
    a_clr: assert property (p_clr) else $error("request stays after clear");
    property p_irq_hold;
        |($past(irq_req) & ~irq_req) |->
            $past(wr_ack && (wb_adr_i == OFS_PENDING || wb_adr_i == OFS_INT_MASK));
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("request fell without software");
    property p_rst_quiet; $rose(rst_n) |-> irq_req == '0 && evt_req == '0 ##1 irq_req == '0; endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active after reset");
    c_irq: cover property (|irq_req);
    c_evt: cover property (|evt_req);
    c_pend_rd: cover property (rd_ack && wb_adr_i == OFS_PENDING && wb_dat_o != '0);
endmodule : ext_event_ctrl_sva
bind ext_event_ctrl ext_event_ctrl_sva #(.N_LINES(N_LINES), .N_EXT(N_EXT), .N_PINS(N_PINS), .SEL_W(SEL_W)) u_sva (
    .clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .gpio_pins(gpio_pins), .int_src(int_src), .irq_req(irq_req), .evt_req(evt_req));
`default_nettype wire

// *** verification/pin_source.sv ***
// External signal sources on the general purpose pins.
// Assumes the bench calls its tasks; levels hold until changed.
`timescale 1ns/100ps
`default_nettype none
module pin_source #(
    parameter int N_PINS = 51
) (
    input  wire logic              clk,  // system clock
    output logic      [N_PINS-1:0] pins  // pin levels
);
    initial pins = '0;
    // slow source: level moves just after an edge
    task automatic set_pin(input int p, input logic v);
        @(posedge clk);
        pins[p] <= v;
    endtask : set_pin
    // glitch of w ns, far below one clock, off the clock phase
    task automatic pulse(input int p, input int w);
        @(posedge clk);
        #(30);
        pins[p] = ~pins[p];
        #(w);
        pins[p] = ~pins[p];
    endtask : pulse
endmodule : pin_source
`default_nettype wire

// *** verification/ext_event_ctrl_bench.sv ***
// Self-checking bench for the external event controller.
// Assumes the checker is bound in and pin_source drives the pins.
`timescale 1ns/100ps
`default_nettype none
module ext_event_ctrl_bench
    import ext_event_pkg::*;
;
    logic                   clk      = 1'b0;
    logic                   rst_n    = 1'b0;
    logic                   cyc      = 1'b0;
    logic                   stb      = 1'b0;
    logic                   we       = 1'b0;
    logic [ADR_W-1:0]       adr      = '0;
    logic [3:0]             sel      = 4'h0;
    logic [DAT_W-1:0]       dat_w    = '0;
    logic [DAT_W-1:0]       dat_r;
    logic                   ack;
    logic [N_PINS_DEF-1:0]  pins;
    logic [2:0]             int_src  = 3'h0;
    logic [N_LINES_DEF-1:0] irq;
    logic [N_LINES_DEF-1:0] evt;
    logic [N_LINES_DEF-1:0] evt_seen = '0;
    logic                   clr_seen = 1'b0;
    logic [DAT_W-1:0]       q;
    logic [DAT_W-1:0]       d;
    logic [7:0]             offs[8]  = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20, 8'h40};
    int                     n_errors = 0;
    int                     n_tests  = 0;
    int                     cycles   = 0;
    int                     n;
    int                     p;
    always #50 clk = ~clk;
    pin_source #(.N_PINS(N_PINS_DEF)) PINS (.clk(clk), .pins(pins));
    ext_event_ctrl DUT (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack), .gpio_pins(pins),
        .int_src(int_src), .irq_req(irq), .evt_req(evt));
    // sticky event catcher, since a pulse may land inside a bus cycle
    always @(posedge clk) evt_seen <= clr_seen ? '0 : (evt_seen | evt);
    // hang guard, far above the under a thousand cycles needed
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_of_test
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // classic cycle: hold everything until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        cyc   <= 1'b1;
        stb   <= 1'b1;
        we    <= w;
        adr   <= a;
        sel   <= 4'hf;
        dat_w <= v;
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        q = dat_r;
        cyc   <= 1'b0;
        stb   <= 1'b0;
    endtask : wb
    function automatic logic [31:0] bit_at(input int i, input logic v);
        return {31'h0, v} << i;
    endfunction : bit_at
    // mode bit 0 picks rising, bit 1 picks falling
    function automatic logic hit_exp(input logic [1:0] mode, input logic rising);
        return rising ? mode[0] : mode[1];
    endfunction : hit_exp
    initial begin
        void'($urandom(31310));
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        foreach (offs[i]) begin
            wb(1'b0, offs[i], '0);
            check("reset value", q, 32'h0);
        end
        $display("test reset values done");
        for (int i = 0; i < 4; i++) begin
            d = $urandom();
            wb(1'b1, 8'(4 * i), d);
            wb(1'b0, 8'(4 * i), '0);
            check("line register", q, d & 32'h0007_ffff);
        end
        n = $urandom_range(15, 0);
        d = $urandom();
        wb(1'b1, 8'h40 + 8'(4 * n), d);
        wb(1'b0, 8'h40 + 8'(4 * n), '0);
        check("selector", q, d & 32'h0000_003f);
        $display("test readback done");
        for (int m = 1; m < 4; m++) begin
            repeat (2) begin
                n = $urandom_range(15, 0);
                p = $urandom_range(50, 0);
                wb(1'b1, OFS_INT_MASK, '0);
                PINS.set_pin(p, 1'b0);
                wb(1'b1, 8'h40 + 8'(4 * n), 32'(p));
                wb(1'b1, OFS_RISE_SEL, bit_at(n, m[0]));
                wb(1'b1, OFS_FALL_SEL, bit_at(n, m[1]));
                wb(1'b1, OFS_PENDING, '1);
                wb(1'b1, OFS_INT_MASK, bit_at(n, 1'b1));
                for (int s = 1; s >= 0; s--) begin
                    PINS.set_pin(p, s[0]);
                    repeat (8) @(posedge clk);
                    wb(1'b0, OFS_PENDING, '0);
                    check("pending after step", q, bit_at(n, hit_exp(2'(m), s[0])));
                    check("request", {31'h0, irq[n]}, {31'h0, hit_exp(2'(m), s[0])});
                    wb(1'b1, OFS_PENDING, bit_at(n, 1'b1));
                end
                PINS.pulse(p, 5);
                repeat (8) @(posedge clk);
                wb(1'b0, OFS_PENDING, '0);
                check("pending after glitch", q, bit_at(n, 1'b1));
                wb(1'b1, OFS_INT_MASK, '0);
                wb(1'b1, OFS_PENDING, '1);
                PINS.pulse(p, 5);
                repeat (8) @(posedge clk);
                wb(1'b0, OFS_PENDING, '0);
                check("masked pending", q, 32'h0);
            end
        end
        $display("test pin edges done");
        for (int j = 16; j < 19; j++) begin
            wb(1'b1, OFS_RISE_SEL, bit_at(j, 1'b1));
            wb(1'b1, OFS_FALL_SEL, '0);
            wb(1'b1, OFS_PENDING, '1);
            wb(1'b1, OFS_INT_MASK, bit_at(j, 1'b1));
            wb(1'b1, OFS_EVT_MASK, bit_at(j, 1'b1));
            @(posedge clk) clr_seen <= 1'b1;
            @(posedge clk) clr_seen <= 1'b0;
            int_src[j-16] <= 1'b1;
            repeat (6) @(posedge clk);
            wb(1'b0, OFS_PENDING, '0);
            check("internal pending", q, bit_at(j, 1'b1));
            check("internal event", 32'(evt_seen), bit_at(j, 1'b1));
            int_src[j-16] <= 1'b0;
            repeat (6) @(posedge clk);
            wb(1'b1, OFS_PENDING, bit_at(j, 1'b1));
            repeat (2) @(posedge clk);
            check("cleared request", 32'(irq), 32'h0);
        end
        n = $urandom_range(15, 0);
        wb(1'b1, OFS_INT_MASK, bit_at(n, 1'b1));
        wb(1'b1, OFS_EVT_MASK, bit_at(n, 1'b1));
        @(posedge clk) clr_seen <= 1'b1;
        @(posedge clk) clr_seen <= 1'b0;
        wb(1'b1, OFS_SW_TRIG, bit_at(n, 1'b1));
        repeat (3) @(posedge clk);
        check("soft event", 32'(evt_seen), bit_at(n, 1'b1));
        wb(1'b0, OFS_PENDING, '0);
        check("soft pending", q, bit_at(n, 1'b1));
        $display("test internal and soft lines done");
        end_of_test();
    end
endmodule : ext_event_ctrl_bench
`default_nettype wire
